/* logic/swp_pkg.sv */
// Constants and types shared by the write-protected serial EEPROM block
package swp_pkg;
    // ========================================
    // Array geometry and instruction framing
    localparam int ADDR_W   = 6;
    localparam int DATA_W   = 16;
    localparam int CMD_BITS = 8;
    localparam int SYNC_W   = 3;
    // ========================================
    // Opcodes, extended codes in address bits [5:4]
    localparam logic [1:0] OP_READ   = 2'h1 + 2'h1;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_EXT    = 2'h0;
    localparam logic [1:0] OP_PRCLR  = 2'h3;
    localparam logic [1:0] EXT_UNLK  = 2'h3;
    localparam logic [1:0] EXT_WRALL = 2'h1;
    localparam logic [1:0] EXT_LOCK  = 2'h0;
    localparam logic [5:0] PRCLR_ADR = 6'h3F;
    localparam logic [5:0] FRZ_ADR   = 6'h00;
    // ========================================
    // Self-timed programming cycle
    localparam int CLK_MHZ      = 25;
    localparam int PROG_TIME_NS = 4000;
    localparam int PROG_CYC     = PROG_TIME_NS * CLK_MHZ / 1000;
    // ========================================
    // Reset values
    localparam logic [5:0] PROT_RST = 6'h00;
    // ========================================
    // Sequencer states and pending programming operations
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_CMD  = 3'b001,
        ST_DATA = 3'b010,
        ST_READ = 3'b011,
        ST_DONE = 3'b100
    } swp_state_e;
    typedef enum logic [2:0]
    {
        PD_NONE  = 3'b000,
        PD_WRITE = 3'b001,
        PD_WRALL = 3'b010,
        PD_PRWR  = 3'b011,
        PD_PRCLR = 3'b100,
        PD_FRZ   = 3'b101
    } swp_pend_e;
endpackage

/* logic/swp_eeprom.sv */
// Serial EEPROM with program lock, write lock and protect register
// What this block does
// - Program-enable pin low refuses every array programming operation.
// - Programming only after unlock instruction, refused again after a lock sent while protect-enable pin is low.
// - Protect register splits array into writable and read-only parts.
// - Host may move the boundary by loading protect register when allowed.
// - Protect-enable pin low blocks every protect register write.
// - Protect-enable pin high lets protect register be programmed.
// - Freeze instruction refuses all later protect register writes until reset.
// - Instructions open with start bit one; input ignored until it comes.
// - Read sends one dummy zero, then the word most significant bit first.
// - Select falling starts programming; select high shows busy then ready.
// - Protect value is first protected address; it and above refuse writes.
`timescale 1ns/1ps
`default_nettype none
module swp_eeprom
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic chip_select,
    input  wire logic serial_clock,
    input  wire logic serial_data_in,
    input  wire logic program_enable_pin,
    input  wire logic protect_enable_pin,
    output logic      serial_data_out,
    output logic      serial_data_out_oe,
    output logic      prog_busy,
    output logic      protect_frozen
);
    localparam int AW = swp_pkg::ADDR_W;
    localparam int DW = swp_pkg::DATA_W;
    localparam int SW = swp_pkg::SYNC_W;
    localparam int TW = $clog2(swp_pkg::PROG_CYC + 1);

    typedef struct packed
    {
        logic [SW-1:0]       sk_sy;
        logic [SW-1:0]       cs_sy;
        logic [SW-1:0]       di_sy;
        logic [SW-1:0]       pe_sy;
        logic [SW-1:0]       pre_sy;
        logic                sk_f;
        logic                cs_f;
        logic                di_f;
        logic                pe_f;
        logic                pre_f;
        swp_pkg::swp_state_e st;
        swp_pkg::swp_pend_e  pend;
        logic [4:0]          cnt;
        logic [DW-1:0]       shreg;
        logic [AW-1:0]       addr;
        logic                rd_prot;
        logic [DW-1:0]       rd_word;
        logic                write_en;
        logic                pr_armed;
        logic                prot_valid;
        logic [AW-1:0]       prot_addr;
        logic                frozen;
        logic                busy;
        logic [TW-1:0]       timer;
        logic                show_stat;
        logic                dout;
        logic                dout_oe;
    } swp_s;

    swp_s          r_reg;
    swp_s          r_next;
    logic [DW-1:0] mem [2**AW];
    logic          mem_we;
    logic          mem_all;
    logic [AW-1:0] mem_wa;
    logic [DW-1:0] mem_wd;
    logic          sk_rise;
    logic          cs_fall;
    logic          allowed;
    logic [7:0]    cmd_byte;

    // Filtered level: a change counts once the second and third stages agree
    function automatic logic filt(input logic [SW-1:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // ========================================
    // Sequencer and lock state
    always_comb
    begin
        r_next             = r_reg;
        mem_we             = 1'b0;
        mem_all            = 1'b0;
        mem_wa             = r_reg.addr;
        mem_wd             = r_reg.shreg;
        r_next.sk_sy       = {r_reg.sk_sy[SW-2:0], serial_clock};
        r_next.cs_sy       = {r_reg.cs_sy[SW-2:0], chip_select};
        r_next.di_sy       = {r_reg.di_sy[SW-2:0], serial_data_in};
        r_next.pe_sy       = {r_reg.pe_sy[SW-2:0], program_enable_pin};
        r_next.pre_sy      = {r_reg.pre_sy[SW-2:0], protect_enable_pin};
        r_next.sk_f        = filt(r_reg.sk_sy, r_reg.sk_f);
        r_next.cs_f        = filt(r_reg.cs_sy, r_reg.cs_f);
        r_next.di_f        = filt(r_reg.di_sy, r_reg.di_f);
        r_next.pe_f        = filt(r_reg.pe_sy, r_reg.pe_f);
        r_next.pre_f       = filt(r_reg.pre_sy, r_reg.pre_f);
        sk_rise            = r_next.sk_f && !r_reg.sk_f && r_reg.cs_f;
        cs_fall            = r_reg.cs_f && !r_next.cs_f;
        cmd_byte           = {r_reg.shreg[6:0], r_reg.di_f};
        // Permission is judged at the moment select falls
        unique case (r_reg.pend)
            swp_pkg::PD_WRITE:
                allowed = r_reg.pe_f && r_reg.write_en
                    && !(r_reg.prot_valid && r_reg.addr >= r_reg.prot_addr);
            swp_pkg::PD_WRALL:
                allowed = r_reg.pe_f && r_reg.write_en && !r_reg.prot_valid;
            swp_pkg::PD_PRWR, swp_pkg::PD_PRCLR, swp_pkg::PD_FRZ:
                allowed = r_reg.pe_f && r_reg.write_en && r_reg.pre_f
                    && !r_reg.frozen;
            default:
                allowed = 1'b0;
        endcase
        // Programming timer
        if (r_reg.busy)
        begin
            r_next.timer = r_reg.timer - TW'(1);
            r_next.busy  = (r_reg.timer != TW'(1));
        end
        if (cs_fall)
        begin
            // Deselect ends any frame; a complete program request starts here
            r_next.st        = swp_pkg::ST_IDLE;
            r_next.pend      = swp_pkg::PD_NONE;
            r_next.show_stat = 1'b0;
            if (r_reg.st == swp_pkg::ST_DONE && allowed)
            begin
                r_next.busy      = 1'b1;
                r_next.timer     = TW'(swp_pkg::PROG_CYC);
                r_next.show_stat = 1'b1;
                unique case (r_reg.pend)
                    swp_pkg::PD_WRITE: mem_we = 1'b1;
                    swp_pkg::PD_WRALL:
                    begin
                        mem_we  = 1'b1;
                        mem_all = 1'b1;
                    end
                    swp_pkg::PD_PRWR:
                    begin
                        r_next.prot_valid = 1'b1;
                        r_next.prot_addr  = r_reg.addr;
                    end
                    swp_pkg::PD_PRCLR:
                    begin
                        r_next.prot_valid = 1'b0;
                        r_next.prot_addr  = swp_pkg::PROT_RST;
                    end
                    default: r_next.frozen = 1'b1;
                endcase
            end
        end
        else if (sk_rise)
        begin
            unique case (r_reg.st)
                swp_pkg::ST_IDLE:
                    if (r_reg.di_f && !r_reg.busy)
                    begin
                        r_next.st        = swp_pkg::ST_CMD;
                        r_next.cnt       = 5'h0;
                        r_next.show_stat = 1'b0;
                    end
                swp_pkg::ST_CMD:
                begin
                    r_next.shreg = {r_reg.shreg[DW-2:0], r_reg.di_f};
                    r_next.cnt   = r_reg.cnt + 5'h1;
                    if (r_reg.cnt == 5'(swp_pkg::CMD_BITS - 1))
                    begin
                        r_next.addr     = cmd_byte[5:0];
                        r_next.cnt      = 5'h0;
                        r_next.st       = swp_pkg::ST_DONE;
                        r_next.pr_armed = 1'b0;
                        if (cmd_byte[7:6] == swp_pkg::OP_READ)
                        begin
                            r_next.st      = swp_pkg::ST_READ;
                            r_next.rd_prot = r_reg.pre_f;
                            r_next.dout    = 1'b0;
                            r_next.dout_oe = 1'b1;
                        end
                        else if (r_reg.pre_f)
                        begin
                            // Protect set: arming must come right before the change
                            if (cmd_byte[7:6] == swp_pkg::OP_EXT && cmd_byte[5:4] == swp_pkg::EXT_UNLK)
                                r_next.pr_armed = r_reg.pe_f && r_reg.write_en;
                            else if (r_reg.pr_armed && cmd_byte[7:6] == swp_pkg::OP_WRITE)
                                r_next.pend = swp_pkg::PD_PRWR;
                            else if (r_reg.pr_armed && cmd_byte == {swp_pkg::OP_PRCLR, swp_pkg::PRCLR_ADR})
                                r_next.pend = swp_pkg::PD_PRCLR;
                            else if (r_reg.pr_armed && cmd_byte == {swp_pkg::OP_EXT, swp_pkg::FRZ_ADR})
                                r_next.pend = swp_pkg::PD_FRZ;
                        end
                        else if (cmd_byte[7:6] == swp_pkg::OP_WRITE)
                        begin
                            r_next.pend = swp_pkg::PD_WRITE;
                            r_next.st   = swp_pkg::ST_DATA;
                        end
                        else if (cmd_byte[7:6] == swp_pkg::OP_EXT)
                        begin
                            unique case (cmd_byte[5:4])
                                swp_pkg::EXT_UNLK: r_next.write_en = 1'b1;
                                swp_pkg::EXT_LOCK: r_next.write_en = 1'b0;
                                swp_pkg::EXT_WRALL:
                                begin
                                    r_next.pend = swp_pkg::PD_WRALL;
                                    r_next.st   = swp_pkg::ST_DATA;
                                end
                                default: r_next.pend = swp_pkg::PD_NONE;
                            endcase
                        end
                    end
                end
                swp_pkg::ST_DATA:
                begin
                    r_next.shreg = {r_reg.shreg[DW-2:0], r_reg.di_f};
                    r_next.cnt   = r_reg.cnt + 5'h1;
                    if (r_reg.cnt == 5'(DW - 1))
                        r_next.st = swp_pkg::ST_DONE;
                end
                swp_pkg::ST_READ:
                begin
                    // Word fetched at each 16-bit boundary, then next address unless reading protect register
                    r_next.cnt = {1'b0, r_reg.cnt[3:0] + 4'h1};
                    if (r_reg.cnt[3:0] == 4'h0)
                    begin
                        r_next.rd_word = r_reg.rd_prot ? {{(DW-AW){1'b0}}, r_reg.prot_addr}
                                                       : mem[r_reg.addr];
                        r_next.dout    = r_next.rd_word[DW-1];
                        r_next.rd_word = {r_next.rd_word[DW-2:0], 1'b0};
                        r_next.addr    = r_reg.rd_prot ? r_reg.addr : r_reg.addr + AW'(1);
                    end
                    else
                    begin
                        r_next.dout    = r_reg.rd_word[DW-1];
                        r_next.rd_word = {r_reg.rd_word[DW-2:0], 1'b0};
                    end
                end
                default: r_next.st = r_reg.st;
            endcase
        end
        // Ready status: low while programming, high once done
        if (r_next.st != swp_pkg::ST_READ)
        begin
            r_next.dout_oe = r_next.show_stat && r_next.cs_f;
            r_next.dout    = !r_next.busy;
        end
        mem_wd = r_reg.shreg;
    end

    // ========================================
    // State register; protect state restarts cleared at every rst assertion
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            r_reg <= '{st: swp_pkg::ST_IDLE, pend: swp_pkg::PD_NONE,
                       prot_addr: swp_pkg::PROT_RST, default: '0};
        else
            r_reg <= r_next;
    end

    // ========================================
    // Array storage; contents are not touched by reset
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 2**AW; i++)
        begin
            if (mem_we && (mem_all || mem_wa == AW'(i)))
                mem[i] <= mem_wd;
        end
    end

    assign serial_data_out    = r_reg.dout;
    assign serial_data_out_oe = r_reg.dout_oe;
    assign prog_busy          = r_reg.busy;
    assign protect_frozen     = r_reg.frozen;

    // ========================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence seq_cs_fall;
        cs_fall && r_reg.st == swp_pkg::ST_DONE;
    endsequence
    sequence seq_read_go;
        sk_rise && r_reg.st == swp_pkg::ST_CMD && r_next.st == swp_pkg::ST_READ;
    endsequence

    a_pe_low_blocks: assert property (mem_we |-> r_reg.pe_f)
        else $error("array written with program enable low");
    a_lock_blocks: assert property (mem_we |-> r_reg.write_en)
        else $error("array written while write locked");
    a_protect_split: assert property (mem_we && !mem_all && r_reg.prot_valid
        |-> mem_wa < r_reg.prot_addr)
        else $error("protected word written");
    a_pre_gates_prot: assert property (r_reg.prot_addr != $past(r_reg.prot_addr)
        |-> $past(r_reg.pre_f) && !$past(r_reg.frozen))
        else $error("protect register changed without access");
    a_freeze_sticks: assert property (r_reg.frozen |=> r_reg.frozen
        && $stable(r_reg.prot_addr) && $stable(r_reg.prot_valid))
        else $error("frozen protect register changed");
    a_start_needed: assert property (sk_rise && r_reg.st == swp_pkg::ST_IDLE
        && !r_reg.di_f |=> r_reg.st == swp_pkg::ST_IDLE)
        else $error("frame started without start bit");
    a_dummy_bit: assert property (seq_read_go |=> r_reg.dout_oe && !r_reg.dout)
        else $error("read dummy bit not zero");
    a_busy_start: assert property (seq_cs_fall ##0 allowed
        |=> r_reg.busy && r_reg.timer == TW'(swp_pkg::PROG_CYC))
        else $error("programming did not start on deselect");
    a_refused_quiet: assert property (seq_cs_fall ##0 !allowed && !r_reg.busy
        |=> !r_reg.busy [*2])
        else $error("refused request started programming");
endmodule
`default_nettype wire

/* dv/swp_host.sv */
// Host microcontroller model: serial master that frames instructions
`timescale 1ns/1ps
`default_nettype none
module swp_host
(
    input  wire logic clock,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe,
    output logic      chip_select,
    output logic      serial_clock,
    output logic      serial_data_in,
    output logic      program_enable_pin,
    output logic      protect_enable_pin
);
    logic do_last;
    logic do_wire;
    // ========================================
    // Released data line shows the inverse of its last level, never a held value
    assign do_wire = serial_data_out_oe ? serial_data_out : ~do_last;
    always @(posedge clock)
    begin
        do_last <= do_wire;
    end
    // Idle levels; serial clock stands low outside frames
    initial
    begin
        do_last            = 1'b0;
        chip_select        = 1'b0;
        serial_clock       = 1'b0;
        serial_data_in     = 1'b0;
        program_enable_pin = 1'b0;
        protect_enable_pin = 1'b0;
    end
    // ========================================
    // Enable pins from software lines; settle past the synchronisers
    task automatic pins(input logic pe, input logic pre);
        @(posedge clock);
        program_enable_pin <= pe;
        protect_enable_pin <= pre;
        repeat (6) @(posedge clock);
    endtask
    // Select from a dedicated output line, one per device
    task automatic sel(input logic v);
        @(posedge clock);
        chip_select <= v;
        repeat (8) @(posedge clock);
    endtask
    // Shift clock is half of a 160 ns host oscillator: 8 of our clocks a bit
    // Shift n bits MSB first; sample just before each rise
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clock);
            serial_clock   <= 1'b0;
            serial_data_in <= tx[i];
            repeat (4) @(posedge clock);
            rx = {rx[30:0], do_wire};
            serial_clock <= 1'b1;
            repeat (3) @(posedge clock);
        end
        @(posedge clock);
        serial_clock <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* dv/swp_eeprom_tb.sv */
// Self-checking bench for the write-protected serial EEPROM
`timescale 1ns/1ps
`default_nettype none
module swp_eeprom_tb;
    localparam logic [5:0] ARM = {swp_pkg::EXT_UNLK, 4'h0};
    logic clock = 1'b0;
    logic rst   = 1'b1;
    logic chip_select;
    logic serial_clock;
    logic serial_data_in;
    logic program_enable_pin;
    logic protect_enable_pin;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic prog_busy;
    logic protect_frozen;
    int   errors;
    int   compares;
    // ========================================
    // 25 MHz clock, device and host wired clock to clock, out to in
    always #20 clock = ~clock;
    swp_eeprom uut
    (
        .clock              (clock),
        .rst                (rst),
        .chip_select        (chip_select),
        .serial_clock       (serial_clock),
        .serial_data_in     (serial_data_in),
        .program_enable_pin (program_enable_pin),
        .protect_enable_pin (protect_enable_pin),
        .serial_data_out    (serial_data_out),
        .serial_data_out_oe (serial_data_out_oe),
        .prog_busy          (prog_busy),
        .protect_frozen     (protect_frozen)
    );
    swp_host host
    (
        .clock              (clock),
        .serial_data_out    (serial_data_out),
        .serial_data_out_oe (serial_data_out_oe),
        .chip_select        (chip_select),
        .serial_clock       (serial_clock),
        .serial_data_in     (serial_data_in),
        .program_enable_pin (program_enable_pin),
        .protect_enable_pin (protect_enable_pin)
    );
    // ========================================
    // Compare and verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ========================================
    // Instruction frames: start bit, opcode, address, optional data
    task automatic frame(input int n, input logic [31:0] bits);
        logic [31:0] rx;
        host.sel(1'b1);
        host.xfer(n, bits, rx);
        host.sel(1'b0);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [5:0] adr);
        frame(9, {23'h0, 1'b1, op, adr});
    endtask
    task automatic wr(input logic [1:0] op, input logic [5:0] adr, input logic [15:0] d);
        frame(25, {7'h0, 1'b1, op, adr, d});
    endtask
    // Two leading zeros ahead of the start bit must be ignored
    task automatic rd(input logic [5:0] adr, input logic [15:0] exp);
        logic [31:0] rx;
        host.sel(1'b1);
        host.xfer(11, {21'h0, 2'b00, 1'b1, swp_pkg::OP_READ, adr}, rx);
        // Dummy bit plus sixteen data bits, one sample ahead of each rise
        host.xfer(17, 32'h0, rx);
        host.sel(1'b0);
        check("dummy", rx[16], 1'b0);
        check("rdata", rx[15:0], exp);
    endtask
    // Programming cycle after deselect, bounded wait for its end
    task automatic done(input logic exp);
        int k;
        repeat (4) @(posedge clock);
        check("busy", prog_busy, exp);
        k = 0;
        while (prog_busy === 1'b1 && k < 300)
        begin
            @(posedge clock);
            k++;
        end
        check("idle", prog_busy, 1'b0);
        if (exp)
            check("cycle", k > 85 && k <= swp_pkg::PROG_CYC, 1'b1);
    endtask
    // ========================================
    // Watchdog well beyond the expected nine thousand cycles
    initial
    begin
        repeat (60000) @(posedge clock);
        errors++;
        conclude();
    end
    // Main sequence
    initial
    begin
        errors   = 0;
        compares = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        check("frozen", protect_frozen, 1'b0);
        host.pins(1'b1, 1'b0);
        wr(swp_pkg::OP_WRITE, 6'h05, 16'h1234);
        done(1'b0);
        cmd(swp_pkg::OP_EXT, ARM);
        wr(swp_pkg::OP_WRITE, 6'h08, 16'h0808);
        done(1'b1);
        wr(swp_pkg::OP_WRITE, 6'h05, 16'h1234);
        host.sel(1'b1);
        check("oe", serial_data_out_oe, 1'b1);
        check("stat", serial_data_out, 1'b0);
        repeat (120) @(posedge clock);
        check("stat", serial_data_out, 1'b1);
        host.sel(1'b0);
        rd(6'h05, 16'h1234);
        cmd(swp_pkg::OP_EXT, {swp_pkg::EXT_LOCK, 4'h0});
        wr(swp_pkg::OP_WRITE, 6'h05, 16'hFFFF);
        done(1'b0);
        rd(6'h05, 16'h1234);
        cmd(swp_pkg::OP_EXT, ARM);
        host.pins(1'b0, 1'b0);
        wr(swp_pkg::OP_WRITE, 6'h05, 16'hFFFF);
        done(1'b0);
        rd(6'h05, 16'h1234);
        // Protect boundary at 8: 8 and above read-only, 7 writable
        host.pins(1'b1, 1'b1);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_WRITE, 6'h08);
        done(1'b1);
        rd(6'h00, 16'h0008);
        host.pins(1'b1, 1'b0);
        wr(swp_pkg::OP_WRITE, 6'h08, 16'hBEEF);
        done(1'b0);
        rd(6'h08, 16'h0808);
        wr(swp_pkg::OP_WRITE, 6'h07, 16'h7777);
        done(1'b1);
        rd(6'h07, 16'h7777);
        // Clear protect, fill all, then write-all refused once protected again
        host.pins(1'b1, 1'b1);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_PRCLR, swp_pkg::PRCLR_ADR);
        done(1'b1);
        rd(6'h00, 16'h0000);
        host.pins(1'b1, 1'b0);
        wr(swp_pkg::OP_EXT, {swp_pkg::EXT_WRALL, 4'h0}, 16'h5A5A);
        done(1'b1);
        rd(6'h3F, 16'h5A5A);
        host.pins(1'b1, 1'b1);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_WRITE, 6'h08);
        done(1'b1);
        host.pins(1'b1, 1'b0);
        wr(swp_pkg::OP_EXT, {swp_pkg::EXT_WRALL, 4'h0}, 16'hA5A5);
        done(1'b0);
        rd(6'h00, 16'h5A5A);
        // Log top down below the boundary; protect value trails the last word
        for (int a = 7; a > 5; a--)
        begin
            host.pins(1'b1, 1'b0);
            wr(swp_pkg::OP_WRITE, 6'(a), 16'(a));
            done(1'b1);
            host.pins(1'b1, 1'b1);
            cmd(swp_pkg::OP_EXT, ARM);
            cmd(swp_pkg::OP_WRITE, 6'(a));
            done(1'b1);
        end
        rd(6'h00, 16'h0006);
        // Freeze: later set and clear attempts are refused
        host.pins(1'b1, 1'b1);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_EXT, swp_pkg::FRZ_ADR);
        done(1'b1);
        check("frozen", protect_frozen, 1'b1);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_WRITE, 6'h10);
        done(1'b0);
        cmd(swp_pkg::OP_EXT, ARM);
        cmd(swp_pkg::OP_PRCLR, swp_pkg::PRCLR_ADR);
        done(1'b0);
        rd(6'h00, 16'h0006);
        // Reset in mid-run: write lock returns, array keeps its contents
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        check("oe", serial_data_out_oe, 1'b0);
        check("busy", prog_busy, 1'b0);
        host.pins(1'b1, 1'b0);
        wr(swp_pkg::OP_WRITE, 6'h05, 16'hFFFF);
        done(1'b0);
        rd(6'h05, 16'h5A5A);
        conclude();
    end
endmodule
`default_nettype wire
